// File: hw/cesf_defines.vh
`ifndef CESF_DEFINES_VH
`define CESF_DEFINES_VH

// Register offsets
`define CESF_OFF_ERR_STATUS  8'h00
`define CESF_OFF_CONTROL     8'h04
`define CESF_OFF_INT_STATUS  8'h08
`define CESF_OFF_INT_MASK    8'h0c

// Error and status field positions
`define CESF_BIT_FORM        24
`define CESF_BIT_BIT         23
`define CESF_BIT_STUCK       22
`define CESF_BIT_CRC         21
`define CESF_BIT_STUFF       20
`define CESF_BIT_ACK         19
`define CESF_BIT_BUS_OFF     18
`define CESF_BIT_PASSIVE     17
`define CESF_BIT_WARNING     16
`define CESF_FLAG_LSB        16
`define CESF_FLAG_MSB        24
`define CESF_STUCK_IDX       6
`define CESF_BIT_SMA         5
`define CESF_BIT_CCE         4
`define CESF_BIT_PDA         3
`define CESF_BIT_RM          1
`define CESF_BIT_TM          0

// Control field positions
`define CESF_CTL_CCR         0
`define CESF_CTL_ABO         1
`define CESF_CTL_SRST        2
`define CESF_CTL_BOSTATE     3

// Reset values
`define CESF_RST_FLAGS       9'h040
`define CESF_RST_LOW_CCE     1'b1
`define CESF_RST_CCR         1'b1
`define CESF_RST_ABO         1'b0
`define CESF_RST_MASK        9'h000

// Fault confinement thresholds
`define CESF_TEC_BUS_OFF     9'h100
`define CESF_TEC_PASSIVE     9'h080
`define CESF_CNT_WARNING     9'h060

// Bus-off recovery counts
`define CESF_RECOV_BITS      11
`define CESF_RECOV_SEQS      128

`endif

// File: hw/cesf_recovery.v
`timescale 1ns/100ps
`include "cesf_defines.vh"

module cesf_recovery #(
    parameter SEQ_BITS = `CESF_RECOV_BITS,
    parameter SEQ_NUM  = `CESF_RECOV_SEQS
) (
    input  wire clk,
    input  wire resetn,
    input  wire enable,
    input  wire bit_tick,
    input  wire bus_recessive,
    output reg  done
);

    reg [3:0] bit_cnt;
    reg [7:0] seq_cnt;

    // Counts runs of eleven recessive bits
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bit_cnt <= 4'h0;
            seq_cnt <= 8'h00;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!enable) begin
                bit_cnt <= 4'h0;
                seq_cnt <= 8'h00;
            end else if (bit_tick) begin
                if (!bus_recessive) begin
                    bit_cnt <= 4'h0;
                end else if (bit_cnt == SEQ_BITS[3:0] - 4'h1) begin
                    bit_cnt <= 4'h0;
                    if (seq_cnt == SEQ_NUM[7:0] - 8'h01) begin
                        seq_cnt <= 8'h00;
                        done    <= 1'b1;
                    end else begin
                        seq_cnt <= seq_cnt + 8'h01;
                    end
                end else begin
                    bit_cnt <= bit_cnt + 4'h1;
                end
            end
        end
    end

endmodule

// File: hw/cesf_error_status.v
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "cesf_defines.vh"

// Notes on behaviour
// - Once any flag other than bit 22 is set, no other flag except bit 22 can be set, so only the first error and any raised in the same cycle are kept.
// - Writing one to a set flag other than bit 22 clears it, after which the other flags update again.
// - Bit 24 is set when a fixed-format field is seen at an illegal level.
// - Bit 23 is set on a bit mismatch outside arbitration or a dominant sent but recessive read in arbitration.
// - Bit 22 is forced to one by hardware reset, software reset or bus-off entry and clears on a recessive bit while no other flag is set.
// - Bit 21 is set when a received checksum does not match.
// - Bits 31 to 25 ignore writes and read zero.
// - After reset flags read zero except bit 22, and of the low bits only bit 4 reads one.
// - Bit 20 is set on a bit-stuffing violation.
// - Bit 19 is set when a transmitted frame is not acknowledged.
// - Bit 18 flags bus-off at a transmit count of 256, the node is silent, and leaving clears the counters.
// - Bit 17 flags a transmit count of 128 and bit 16 flags either count at 96.
module cesf_error_status #(
    parameter RECOV_BITS = `CESF_RECOV_BITS,
    parameter RECOV_SEQS = `CESF_RECOV_SEQS
) (
    input  wire        clk,
    input  wire        resetn,
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [31:0] rdata,
    input  wire        form_error_event,
    input  wire        bit_error_event,
    input  wire        checksum_error_event,
    input  wire        stuffing_error_event,
    input  wire        no_ack_error_event,
    input  wire        bit_tick,
    input  wire        bus_recessive,
    input  wire [8:0]  transmit_error_counter,
    input  wire [7:0]  receive_error_counter,
    input  wire        config_change_status_in,
    input  wire        sma_status_in,
    input  wire        pda_status_in,
    input  wire        rm_status_in,
    input  wire        tm_status_in,
    output reg         bus_off_active,
    output reg         counters_clear,
    output reg         config_change_request,
    output reg         irq
);

    // Bus decode shared by read and write paths
    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // True when any clearable flag other than idx is set
    function others_set;
        input [8:0] f;
        input integer idx;
        reg   [8:0] m;
        begin
            m = f;
            m[idx] = 1'b0;
            m[`CESF_STUCK_IDX] = 1'b0;
            others_set = |m;
        end
    endfunction

    reg  [8:0]  flags;
    reg  [8:0]  next_flags;
    reg  [5:0]  low_status;
    reg         auto_bus_on;
    reg  [8:0]  int_status;
    reg  [8:0]  int_mask;
    reg         warn_prev;
    reg         passive_prev;
    reg         soft_reset;
    reg  [8:0]  next_int_status;
    reg  [31:0] next_rdata;

    wire        wr_es;
    wire        wr_ctl;
    wire        wr_mask;
    wire        rd_int;
    wire        warn_cond;
    wire        passive_cond;
    wire        bo_cond;
    wire        bo_entry;
    wire        recov_done;
    wire        ccr_cleared;
    wire        bo_exit;
    wire [8:0]  events;

    assign wr_es  = wr && hit(addr, `CESF_OFF_ERR_STATUS);
    assign wr_ctl = wr && hit(addr, `CESF_OFF_CONTROL);
    assign wr_mask = wr && hit(addr, `CESF_OFF_INT_MASK);
    assign rd_int = rd && hit(addr, `CESF_OFF_INT_STATUS);

    // Fault confinement thresholds
    assign warn_cond    = (transmit_error_counter >= `CESF_CNT_WARNING) ||
                          ({1'b0, receive_error_counter} >= `CESF_CNT_WARNING);
    assign passive_cond = (transmit_error_counter >= `CESF_TEC_PASSIVE);
    assign bo_cond      = (transmit_error_counter >= `CESF_TEC_BUS_OFF);
    assign bo_entry     = bo_cond && !bus_off_active;

    // Leaving bus-off: software drops the request, or auto recovery ends
    assign ccr_cleared = wr_ctl && bus_off_active && !wdata[`CESF_CTL_CCR];
    assign bo_exit     = bus_off_active && (ccr_cleared || (auto_bus_on && recov_done));

    // Event vector in flag order, bit 16 upward
    assign events[0] = warn_cond && !warn_prev;
    assign events[1] = passive_cond && !passive_prev;
    assign events[2] = bo_entry;
    assign events[3] = no_ack_error_event;
    assign events[4] = stuffing_error_event;
    assign events[5] = checksum_error_event;
    assign events[6] = 1'b0;
    assign events[7] = bit_error_event;
    assign events[8] = form_error_event;

    cesf_recovery #(
        .SEQ_BITS (RECOV_BITS),
        .SEQ_NUM  (RECOV_SEQS)
    ) u_recovery (
        .clk           (clk),
        .resetn        (resetn),
        .enable        (bus_off_active && auto_bus_on),
        .bit_tick      (bit_tick),
        .bus_recessive (bus_recessive),
        .done          (recov_done)
    );

    // Next value of each flag
    genvar gi;
    generate
        for (gi = 0; gi < 9; gi = gi + 1) begin : g_flag
            if (gi == `CESF_STUCK_IDX) begin : g_stuck
                always @* begin
                    next_flags[gi] = flags[gi];
                    if (soft_reset || bo_entry) begin
                        next_flags[gi] = 1'b1;
                    end else if (bit_tick && bus_recessive && !others_set(flags, gi)) begin
                        next_flags[gi] = 1'b0;
                    end
                end
            end else begin : g_clear
                always @* begin
                    next_flags[gi] = flags[gi];
                    if (soft_reset) begin
                        next_flags[gi] = 1'b0;
                    end else if (events[gi] && !others_set(flags, gi)) begin
                        next_flags[gi] = 1'b1;
                    end else if (wr_es && wdata[`CESF_FLAG_LSB + gi]) begin
                        next_flags[gi] = 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Flags, threshold history
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags        <= `CESF_RST_FLAGS;
            warn_prev    <= 1'b0;
            passive_prev <= 1'b0;
        end else begin
            flags        <= next_flags;
            warn_prev    <= warn_cond;
            passive_prev <= passive_cond;
        end
    end

    // Read-only low status bits follow the engine
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            low_status <= 6'h00;
            low_status[`CESF_BIT_CCE] <= `CESF_RST_LOW_CCE;
        end else begin
            low_status[`CESF_BIT_SMA] <= sma_status_in;
            low_status[`CESF_BIT_CCE] <= config_change_status_in;
            low_status[`CESF_BIT_PDA] <= pda_status_in;
            low_status[2]             <= 1'b0;
            low_status[`CESF_BIT_RM]  <= rm_status_in;
            low_status[`CESF_BIT_TM]  <= tm_status_in;
        end
    end

    // Control register and software reset pulse
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            config_change_request <= `CESF_RST_CCR;
            auto_bus_on           <= `CESF_RST_ABO;
            soft_reset            <= 1'b0;
        end else begin
            soft_reset <= wr_ctl && wdata[`CESF_CTL_SRST];
            if (bo_entry) begin
                config_change_request <= 1'b1;
            end else if (wr_ctl) begin
                config_change_request <= wdata[`CESF_CTL_CCR];
            end
            if (wr_ctl) begin
                auto_bus_on <= wdata[`CESF_CTL_ABO];
            end
        end
    end

    // Bus-off state and counter clear
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_off_active <= 1'b0;
            counters_clear <= 1'b0;
        end else begin
            counters_clear <= bo_exit;
            if (bo_entry) begin
                bus_off_active <= 1'b1;
            end else if (bo_exit) begin
                bus_off_active <= 1'b0;
            end
        end
    end

    // Sticky interrupt status, read clears, set wins
    always @* begin
        next_int_status = int_status;
        if (rd_int) begin
            next_int_status = 9'h000;
        end
        next_int_status = next_int_status | (next_flags & ~flags);
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            int_status <= 9'h000;
            int_mask   <= `CESF_RST_MASK;
            irq        <= 1'b0;
        end else begin
            int_status <= next_int_status;
            irq        <= |(next_int_status & (wr_mask ? wdata[8:0] : int_mask));
            if (wr_mask) begin
                int_mask <= wdata[8:0];
            end
        end
    end

    // Read data, one cycle after the strobe
    always @* begin
        next_rdata = 32'h0000_0000;
        if (hit(addr, `CESF_OFF_ERR_STATUS)) begin
            next_rdata[`CESF_FLAG_MSB:`CESF_FLAG_LSB] = flags;
            next_rdata[5:0] = low_status;
        end else if (hit(addr, `CESF_OFF_CONTROL)) begin
            next_rdata[`CESF_CTL_CCR]     = config_change_request;
            next_rdata[`CESF_CTL_ABO]     = auto_bus_on;
            next_rdata[`CESF_CTL_BOSTATE] = bus_off_active;
        end else if (hit(addr, `CESF_OFF_INT_STATUS)) begin
            next_rdata[8:0] = int_status;
        end else if (hit(addr, `CESF_OFF_INT_MASK)) begin
            next_rdata[8:0] = int_mask;
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

endmodule

// File: testbench/cesf_error_status_assertions.sv
`timescale 1ns/100ps
module cesf_checker (
    input wire        clk,
    input wire        resetn,
    input wire [7:0]  addr,
    input wire [31:0] wdata,
    input wire        wr,
    input wire        rd,
    input wire [31:0] rdata,
    input wire [8:0]  transmit_error_counter,
    input wire        bus_off_active,
    input wire        counters_clear,
    input wire        config_change_request,
    input wire        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_rd_idle; !$past(rd) |-> rdata == 32'h0000_0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero outside read");
    property p_rsv; $past(rd) |-> rdata[31:25] == 7'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
    property p_entry; !bus_off_active && transmit_error_counter >= 9'h100 |=> bus_off_active; endproperty
    a_entry: assert property (p_entry) else $error("bus-off not entered");
    property p_ccr_entry; $rose(bus_off_active) |-> config_change_request; endproperty
    a_ccr_entry: assert property (p_ccr_entry) else $error("request not forced at bus-off");
    property p_exit; bus_off_active && wr && addr == 8'h04 && !wdata[0] |=> !bus_off_active; endproperty
    a_exit: assert property (p_exit) else $error("bus-off not left on request clear");
    property p_clr; $fell(bus_off_active) |-> ##[0:1] counters_clear; endproperty
    a_clr: assert property (p_clr) else $error("counter clear missing");
    property p_clr_pulse; counters_clear |=> !counters_clear && !bus_off_active; endproperty
    a_clr_pulse: assert property (p_clr_pulse) else $error("counter clear too long");
    property p_ccr_wr;
        wr && addr == 8'h04 && (bus_off_active || transmit_error_counter < 9'h100)
            |=> config_change_request == $past(wdata[0]);
    endproperty
    a_ccr_wr: assert property (p_ccr_wr) else $error("request bit not written");
    property p_mask; wr && addr == 8'h0c && wdata[8:0] == 9'h000 |=> !irq; endproperty
    a_mask: assert property (p_mask) else $error("irq with empty mask");
endmodule

// File: testbench/cesf_bus_model.sv
`timescale 1ns/100ps
module cesf_bus_model (
    input  wire       clk,
    input  wire       counters_clear,
    output reg  [4:0] events,
    output reg        bit_tick,
    output reg        bus_recessive,
    output reg  [8:0] tec,
    output reg  [7:0] rec
);
    initial begin
        events = 5'h0;
        bit_tick = 1'b0;
        bus_recessive = 1'b0;
        tec = 9'h000;
        rec = 8'h00;
    end
    // Counters restart after bus-off
    always @(posedge clk) begin
        if (counters_clear) begin
            tec <= 9'h000;
            rec <= 8'h00;
        end
    end
    task pulse(input [4:0] m);
        begin
            @(posedge clk) events <= m;
            @(posedge clk) events <= 5'h0;
        end
    endtask
    // Bus level is valid only with the tick
    task send_bits(input integer n, input r);
        begin
            repeat (n) begin
                @(posedge clk) bit_tick <= 1'b1;
                bus_recessive <= r;
                @(posedge clk) bit_tick <= 1'b0;
                bus_recessive <= ~r;
            end
        end
    endtask
    task set_counts(input [8:0] t, input [7:0] r);
        begin
            @(posedge clk) tec <= t;
            rec <= r;
        end
    endtask
endmodule

// File: testbench/test_can_error_status_flags.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_can_error_status_flags;
    reg         clk, resetn, wr, rd;
    reg  [7:0]  addr;
    reg  [31:0] wdata, d;
    reg  [4:0]  st_in;
    wire [31:0] rdata;
    wire [4:0]  events;
    wire [8:0]  tec;
    wire [7:0]  rec;
    wire        bit_tick, bus_recessive, bus_off_active, counters_clear, config_change_request, irq;
    integer     n_errors, cmp_count, cycles, i, b;
    cesf_error_status #(.RECOV_SEQS(2)) u_dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .form_error_event(events[4]), .bit_error_event(events[3]),
        .checksum_error_event(events[2]), .stuffing_error_event(events[1]), .no_ack_error_event(events[0]),
        .bit_tick(bit_tick), .bus_recessive(bus_recessive), .transmit_error_counter(tec),
        .receive_error_counter(rec), .config_change_status_in(st_in[4]), .sma_status_in(st_in[3]),
        .pda_status_in(st_in[2]), .rm_status_in(st_in[1]), .tm_status_in(st_in[0]),
        .bus_off_active(bus_off_active),
        .counters_clear(counters_clear), .config_change_request(config_change_request), .irq(irq));
    cesf_bus_model u_bus (.clk(clk), .counters_clear(counters_clear), .events(events), .bit_tick(bit_tick),
        .bus_recessive(bus_recessive), .tec(tec), .rec(rec));
    task wr_reg(input [7:0] a, input [31:0] v);
        begin
            @(posedge clk) addr <= a;
            wdata <= v;
            wr <= 1'b1;
            @(posedge clk) wr <= 1'b0;
        end
    endtask
    task chk_reg(input [7:0] a, input [31:0] m, input [31:0] e);
        begin
            @(posedge clk) addr <= a;
            rd <= 1'b1;
            @(posedge clk) rd <= 1'b0;
            #1 d = rdata & m;
            `CHK("reg", e, d)
        end
    endtask
    task t_reset;
        begin
            chk_reg(8'h00, 32'hffff_ffff, 32'h0040_0010);
            chk_reg(8'h04, 32'h0000_000f, 32'h0000_0001);
            chk_reg(8'h10, 32'hffff_ffff, 32'h0000_0000);
        end
    endtask
    // Low status bits mirror the engine and ignore writes
    task t_low;
        begin
            @(posedge clk) st_in <= 5'h0f;
            chk_reg(8'h00, 32'h0000_003f, 32'h0000_002b);
            wr_reg(8'h00, 32'h0000_0014);
            chk_reg(8'h00, 32'h0000_003f, 32'h0000_002b);
            @(posedge clk) st_in <= 5'h10;
            chk_reg(8'h00, 32'h0000_003f, 32'h0000_0010);
        end
    endtask
    task t_stuck;
        begin
            u_bus.send_bits(1, 1'b1);
            chk_reg(8'h00, 32'h0040_0000, 32'h0000_0000);
            wr_reg(8'h04, 32'h0000_0005);
            chk_reg(8'h00, 32'h0040_0000, 32'h0040_0000);
            u_bus.send_bits(1, 1'b1);
        end
    endtask
    task t_flags;
        begin
            for (i = 0; i < 5; i++) begin
                b = (i < 2) ? 24 - i : 23 - i;
                u_bus.pulse(5'h10 >> i);
                chk_reg(8'h00, 32'h01ff_0000, 32'h1 << b);
                u_bus.pulse((i == 0) ? 5'h01 : 5'h10);
                chk_reg(8'h00, 32'h01ff_0000, 32'h1 << b);
                wr_reg(8'h00, ~(32'h1 << b));
                chk_reg(8'h00, 32'hffff_ffff, (32'h1 << b) | 32'h10);
                wr_reg(8'h00, 32'h1 << b);
                chk_reg(8'h00, 32'h01ff_0000, 32'h0000_0000);
            end
        end
    endtask
    task t_irq;
        begin
            chk_reg(8'h08, 32'hffff_ffff, 32'h0000_01f8);
            wr_reg(8'h0c, 32'h0000_0080);
            u_bus.pulse(5'h08);
            #1 `CHK("irq", 1'b1, irq)
            chk_reg(8'h08, 32'hffff_ffff, 32'h0000_0080);
            `CHK("irq", 1'b0, irq)
            wr_reg(8'h00, 32'h0080_0000);
            wr_reg(8'h0c, 32'h0000_0000);
            u_bus.pulse(5'h08);
            repeat (2) @(posedge clk);
            `CHK("irq", 1'b0, irq)
            wr_reg(8'h00, 32'h0080_0000);
            chk_reg(8'h08, 32'hffff_ffff, 32'h0000_0080);
        end
    endtask
    task t_thresh;
        begin
            u_bus.set_counts(9'h060, 8'h00);
            chk_reg(8'h00, 32'h01ff_0000, 32'h0001_0000);
            wr_reg(8'h00, 32'h0001_0000);
            u_bus.set_counts(9'h080, 8'h00);
            chk_reg(8'h00, 32'h01ff_0000, 32'h0002_0000);
            wr_reg(8'h00, 32'h0002_0000);
            u_bus.set_counts(9'h000, 8'h00);
            u_bus.set_counts(9'h000, 8'h60);
            chk_reg(8'h00, 32'h01ff_0000, 32'h0001_0000);
            wr_reg(8'h00, 32'h0001_0000);
            u_bus.set_counts(9'h000, 8'h00);
        end
    endtask
    task t_busoff;
        begin
            u_bus.set_counts(9'h100, 8'h05);
            repeat (2) @(posedge clk);
            `CHK("bus_off", 1'b1, bus_off_active)
            chk_reg(8'h00, 32'h0044_0000, 32'h0044_0000);
            chk_reg(8'h04, 32'h0000_0009, 32'h0000_0009);
            u_bus.set_counts(9'h000, 8'h05);
            wr_reg(8'h04, 32'h0000_0000);
            #1 `CHK("bus_off", 1'b0, bus_off_active)
            `CHK("counters_clear", 1'b1, counters_clear)
            repeat (3) @(posedge clk);
            `CHK("rec", 8'h00, rec)
            wr_reg(8'h00, 32'h01ff_0000);
            wr_reg(8'h04, 32'h0000_0002);
            u_bus.set_counts(9'h100, 8'h00);
            repeat (2) @(posedge clk);
            `CHK("ccr", 1'b1, config_change_request)
            u_bus.set_counts(9'h000, 8'h00);
            u_bus.send_bits(5, 1'b1);
            u_bus.send_bits(1, 1'b0);
            u_bus.send_bits(21, 1'b1);
            `CHK("bus_off", 1'b1, bus_off_active)
            u_bus.send_bits(1, 1'b1);
            repeat (3) @(posedge clk);
            `CHK("bus_off", 1'b0, bus_off_active)
            wr_reg(8'h00, 32'h01ff_0000);
        end
    endtask
    task wrap_up;
        begin
            $display("mismatches %0d compares %0d", n_errors, cmp_count);
            if (n_errors == 0 && cmp_count > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_errors++;
            wrap_up;
        end
    end
    initial begin
        {resetn, wr, rd, addr, wdata} = 0;
        {n_errors, cmp_count, cycles} = 0;
        st_in = 5'h10;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        t_reset;
        t_low;
        t_stuck;
        t_flags;
        t_irq;
        t_thresh;
        t_busoff;
        wrap_up;
    end
endmodule
bind cesf_error_status cesf_checker u_chk (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .transmit_error_counter(transmit_error_counter), .bus_off_active(bus_off_active),
    .counters_clear(counters_clear), .config_change_request(config_change_request), .irq(irq));
